//--- hdl/rtcr_cfg.svh
// Register offsets, field positions, reset values and rate counts for the control bank
`ifndef RTCR_CFG_SVH
`define RTCR_CFG_SVH

`define RTCR_OFS_CFG2      8'h01
`define RTCR_OFS_POL       8'h02
`define RTCR_OFS_TMR       8'h03
`define RTCR_OFS_IEN       8'h04
`define RTCR_OFS_STAT      8'h05
`define RTCR_OFS_TIME_LO   8'h06
`define RTCR_OFS_TIME_HI   8'h0c
`define RTCR_OFS_TINIT     8'h10

`define RTCR_CFG2_RST      8'h0c
`define RTCR_POL_RST       8'h00
`define RTCR_TMR_RST       8'h07
`define RTCR_IEN_RST       8'h00
`define RTCR_STAT_RST      8'h40

`define RTCR_B_RETEN       6
`define RTCR_B_THR_HI      5
`define RTCR_B_THR_LO      4
`define RTCR_B_TMO         3
`define RTCR_B_RDLIVE      2
`define RTCR_B_LOAD        1
`define RTCR_B_APOL        6
`define RTCR_B_DPOL        5
`define RTCR_B_HOLD        5
`define RTCR_B_RUN         4
`define RTCR_B_RPT         2
`define RTCR_B_OSMASK      6
`define RTCR_B_OSF         6
`define RTCR_B_ANA         5
`define RTCR_B_DIG         4
`define RTCR_B_TMR         2
`define RTCR_B_AL2         1
`define RTCR_B_AL1         0

`define RTCR_CFG2_MASK     8'h7e
`define RTCR_POL_MASK      8'h60
`define RTCR_TMR_MASK      8'h37
`define RTCR_IEN_MASK      8'h77

// Base tick in Hz; rate codes divide it by 1, 4, 16, 64
`define RTCR_BASE_HZ       1024
`define RTCR_CLK_HZ        100000000
`define RTCR_BASE_DIV      (`RTCR_CLK_HZ / `RTCR_BASE_HZ)

`endif

//--- hdl/rtcr_pkg.sv
// Types shared by the control bank
package rtcr_pkg;
  typedef enum logic [1:0] {
    RTCR_TMR_IDLE = 2'b00,
    RTCR_TMR_RUN  = 2'b01,
    RTCR_TMR_HOLD = 2'b11,
    RTCR_TMR_DONE = 2'b10
  } rtcr_tmr_state_type;
endpackage : rtcr_pkg

//--- hdl/rtcr_edge_det.sv
// Polarity-selectable edge detector for one event input
`timescale 1ns/1ps
module rtcr_edge_det
(
  ref_clk,
  rst,
  sig_in,
  rising_sel,
  edge_pulse
);
  input  wire logic ref_clk;
  input  wire logic rst;
  input  wire logic sig_in;
  input  wire logic rising_sel;
  output logic      edge_pulse;

  typedef struct packed
  {
    logic prev;
    logic armed;
  } rtcr_edge_state_type;

  rtcr_edge_state_type state_ff;
  rtcr_edge_state_type nxt_state;

  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.prev  = sig_in;
    nxt_state.armed = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Armed blocks a false edge on the first cycle after reset
  assign edge_pulse = state_ff.armed &
                      (rising_sel ? (sig_in & ~state_ff.prev) : (~sig_in & state_ff.prev));
endmodule : rtcr_edge_det

//--- hdl/rtcr_ctrl_regs.sv
// Control register bank with countdown timer and interrupt gating
//
// Function
// - Retention mode bit 6, resets zero
// - Comparator threshold code bits 5:4, reset 0
// - Bit 2 picks live or programmed time
// - Rising load bit copies time to chain
// - Analog edge polarity bit 6, reset falling
// - Digital edge polarity bit 5, reset falling
// - Hold freezes countdown only while running
// - Run low resets timer, high counts
// - No autoreload: stop at zero
// - Autoreload: reload initial count at zero
// - Rate code 1024/256/64/16 Hz, reset 3
// - Oscillator flag mask forces flag zero
// - Per-source irq enables, all reset zero
// - Timer flag at zero; status read clears
// - Output select: square wave or interrupt
`timescale 1ns/1ps
`include "rtcr_cfg.svh"
module rtcr_ctrl_regs
  import rtcr_pkg::*;
#(
  parameter int BASE_DIV = `RTCR_BASE_DIV
)
(
  ref_clk,
  rst,
  reg_addr,
  reg_wr,
  reg_rd,
  reg_wdata,
  reg_rdata,
  time_live,
  alarm1_evt,
  alarm2_evt,
  osc_stopped,
  analog_input_pin,
  digital_input_pin,
  square_wave,
  output_function_sel,
  retention_mode_sel,
  comparator_threshold_sel,
  bus_timeout_en,
  time_load,
  time_prog,
  irq_pin_out
);
  input  wire logic       ref_clk;
  input  wire logic       rst;
  input  wire logic [7:0] reg_addr;
  input  wire logic       reg_wr;
  input  wire logic       reg_rd;
  input  wire logic [7:0] reg_wdata;
  output logic      [7:0] reg_rdata;
  input  wire logic [55:0] time_live;
  input  wire logic       alarm1_evt;
  input  wire logic       alarm2_evt;
  input  wire logic       osc_stopped;
  input  wire logic       analog_input_pin;
  input  wire logic       digital_input_pin;
  input  wire logic       square_wave;
  input  wire logic       output_function_sel;
  output logic            retention_mode_sel;
  output logic      [1:0] comparator_threshold_sel;
  output logic            bus_timeout_en;
  output logic            time_load;
  output logic      [55:0] time_prog;
  output logic            irq_pin_out;

  typedef struct packed
  {
    logic [7:0]         cfg2;
    logic [7:0]         pol;
    logic [7:0]         tmr;
    logic [7:0]         ien;
    logic [7:0]         stat;
    logic [7:0]         tinit;
    logic [7:0]         count;
    logic [55:0]        tprog;
    logic [31:0]        div;
    logic [5:0]         pre;
    rtcr_tmr_state_type tst;
    logic               load;
    logic [7:0]         rdata;
    logic               irq;
  } rtcr_state_type;

  rtcr_state_type s_ff;
  rtcr_state_type nxt_s;
  logic           ana_edge;
  logic           dig_edge;

  // --------------------------------------------------------------
  // Input edge detection
  // --------------------------------------------------------------
  rtcr_edge_det u_ana_edge
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sig_in     (analog_input_pin),
    .rising_sel (s_ff.pol[`RTCR_B_APOL]),
    .edge_pulse (ana_edge)
  );

  rtcr_edge_det u_dig_edge
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .sig_in     (digital_input_pin),
    .rising_sel (s_ff.pol[`RTCR_B_DPOL]),
    .edge_pulse (dig_edge)
  );

  function automatic logic [5:0] rate_mask(input logic [1:0] code);
    case (code)
      2'h0:    rate_mask = 6'h00;
      2'h1:    rate_mask = 6'h03;
      2'h2:    rate_mask = 6'h0f;
      default: rate_mask = 6'h3f;
    endcase
  endfunction : rate_mask

  function automatic logic is_time(input logic [7:0] a);
    is_time = (a >= `RTCR_OFS_TIME_LO) && (a <= `RTCR_OFS_TIME_HI);
  endfunction : is_time

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  always_comb
  begin
    logic       tick;
    logic       at_zero;
    logic [2:0] idx;
    logic       wr_cfg2;
    logic [7:0] new_cfg2;
    nxt_s    = s_ff;
    tick     = 1'b0;
    at_zero  = 1'b0;
    idx      = 3'(reg_addr - `RTCR_OFS_TIME_LO);
    wr_cfg2  = reg_wr && (reg_addr == `RTCR_OFS_CFG2);
    new_cfg2 = reg_wdata & `RTCR_CFG2_MASK;
    nxt_s.load = 1'b0;

    // Register writes
    if (wr_cfg2)
    begin
      nxt_s.cfg2 = new_cfg2;
      // Only a rising load bit fires; a held one stays quiet
      nxt_s.load = new_cfg2[`RTCR_B_LOAD] & ~s_ff.cfg2[`RTCR_B_LOAD];
    end
    if (reg_wr && (reg_addr == `RTCR_OFS_POL))
      nxt_s.pol = reg_wdata & `RTCR_POL_MASK;
    if (reg_wr && (reg_addr == `RTCR_OFS_TMR))
      nxt_s.tmr = reg_wdata & `RTCR_TMR_MASK;
    if (reg_wr && (reg_addr == `RTCR_OFS_IEN))
      nxt_s.ien = reg_wdata & `RTCR_IEN_MASK;
    // Initial count accepted only while the timer is held in reset
    if (reg_wr && (reg_addr == `RTCR_OFS_TINIT) && !s_ff.tmr[`RTCR_B_RUN])
      nxt_s.tinit = reg_wdata;
    if (reg_wr && is_time(reg_addr))
      nxt_s.tprog[idx*8 +: 8] = reg_wdata;

    // Base tick divider, then prescaler by rate code
    if (s_ff.tst == RTCR_TMR_RUN)
    begin
      if (s_ff.div >= 32'(BASE_DIV - 1))
      begin
        nxt_s.div = '0;
        nxt_s.pre = s_ff.pre + 6'h01;
        tick      = ((s_ff.pre & rate_mask(s_ff.tmr[1:0])) == rate_mask(s_ff.tmr[1:0]));
      end
      else
      begin
        nxt_s.div = s_ff.div + 32'h1;
      end
    end
    at_zero = tick && (s_ff.count == 8'h01);

    // Countdown state machine
    case (s_ff.tst)
      RTCR_TMR_IDLE:
      begin
        nxt_s.count = s_ff.tinit;
        nxt_s.div   = '0;
        nxt_s.pre   = '0;
        if (s_ff.tmr[`RTCR_B_RUN])
          nxt_s.tst = (s_ff.tinit == 8'h00) ? RTCR_TMR_DONE : RTCR_TMR_RUN;
      end
      RTCR_TMR_RUN:
      begin
        if (s_ff.tmr[`RTCR_B_HOLD])
          nxt_s.tst = RTCR_TMR_HOLD;
        else if (tick)
        begin
          nxt_s.count = s_ff.count - 8'h01;
          if (at_zero && s_ff.tmr[`RTCR_B_RPT])
            nxt_s.count = s_ff.tinit;
          else if (at_zero)
            nxt_s.tst = RTCR_TMR_DONE;
        end
      end
      RTCR_TMR_HOLD:
      begin
        if (!s_ff.tmr[`RTCR_B_HOLD])
          nxt_s.tst = RTCR_TMR_RUN;
      end
      RTCR_TMR_DONE:
      begin
        nxt_s.count = 8'h00;
      end
      default:
      begin
        nxt_s.tst = RTCR_TMR_IDLE;
      end
    endcase
    if (!s_ff.tmr[`RTCR_B_RUN])
      nxt_s.tst = RTCR_TMR_IDLE;

    // Read data, from flops; status read clears all flags
    nxt_s.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `RTCR_OFS_CFG2:  nxt_s.rdata = s_ff.cfg2;
        `RTCR_OFS_POL:   nxt_s.rdata = s_ff.pol;
        `RTCR_OFS_TMR:   nxt_s.rdata = s_ff.tmr;
        `RTCR_OFS_IEN:   nxt_s.rdata = s_ff.ien;
        `RTCR_OFS_STAT:  nxt_s.rdata = s_ff.stat;
        `RTCR_OFS_TINIT: nxt_s.rdata = s_ff.count;
        default:
        begin
          if (is_time(reg_addr))
            nxt_s.rdata = s_ff.cfg2[`RTCR_B_RDLIVE] ? time_live[idx*8 +: 8]
                                                    : s_ff.tprog[idx*8 +: 8];
        end
      endcase
    end
    if (reg_rd && (reg_addr == `RTCR_OFS_STAT))
      nxt_s.stat = 8'h00;

    // Events set after the clear so a same-cycle event wins
    if (at_zero || ((s_ff.tst == RTCR_TMR_IDLE) && s_ff.tmr[`RTCR_B_RUN] && (s_ff.tinit == 8'h00)))
      nxt_s.stat[`RTCR_B_TMR] = 1'b1;
    if (ana_edge)
      nxt_s.stat[`RTCR_B_ANA] = 1'b1;
    if (dig_edge)
      nxt_s.stat[`RTCR_B_DIG] = 1'b1;
    if (alarm1_evt)
      nxt_s.stat[`RTCR_B_AL1] = 1'b1;
    if (alarm2_evt)
      nxt_s.stat[`RTCR_B_AL2] = 1'b1;
    if (osc_stopped)
      nxt_s.stat[`RTCR_B_OSF] = 1'b1;
    if (s_ff.ien[`RTCR_B_OSMASK])
      nxt_s.stat[`RTCR_B_OSF] = 1'b0;

    nxt_s.irq = |(nxt_s.stat & s_ff.ien & 8'h37);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_ff       <= '0;
      s_ff.cfg2  <= `RTCR_CFG2_RST;
      s_ff.pol   <= `RTCR_POL_RST;
      s_ff.tmr   <= `RTCR_TMR_RST;
      s_ff.ien   <= `RTCR_IEN_RST;
      s_ff.stat  <= `RTCR_STAT_RST;
      s_ff.tst   <= RTCR_TMR_IDLE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign reg_rdata                = s_ff.rdata;
  assign retention_mode_sel       = s_ff.cfg2[`RTCR_B_RETEN];
  assign comparator_threshold_sel = s_ff.cfg2[`RTCR_B_THR_HI:`RTCR_B_THR_LO];
  assign bus_timeout_en           = s_ff.cfg2[`RTCR_B_TMO];
  assign time_load                = s_ff.load;
  assign time_prog                = s_ff.tprog;
  // Pin mux is a plain gate; both inputs already come from flops
  assign irq_pin_out = output_function_sel ? s_ff.irq : square_wave;
endmodule : rtcr_ctrl_regs

//--- testbench/rtcr_ctrl_regs_checker.sv
// Assertion checker for the control register bank
`timescale 1ns/1ps
module rtcr_ctrl_regs_checker
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic       square_wave,
  input wire logic       output_function_sel,
  input wire logic       retention_mode_sel,
  input wire logic [1:0] comparator_threshold_sel,
  input wire logic       bus_timeout_en,
  input wire logic       time_load,
  input wire logic       irq_pin_out
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic cfg2_wr;
  logic load_req;
  logic load_bit_ff;
  logic [7:0] ien_ff;
  logic [7:0] ien_old_ff;
  assign cfg2_wr = reg_wr && reg_addr == 8'h01;
  // Only a 0 to 1 step of the stored bit may load
  assign load_req = cfg2_wr && reg_wdata[1] && !load_bit_ff;
  always_ff @(posedge ref_clk)
  begin
    load_bit_ff <= rst ? 1'b0 : (cfg2_wr ? reg_wdata[1] : load_bit_ff);
    // Old enables kept too: irq is registered from the enables before a write
    ien_ff <= rst ? 8'h00 : ((reg_wr && reg_addr == 8'h04) ? (reg_wdata & 8'h37) : ien_ff);
    ien_old_ff <= rst ? 8'h00 : ien_ff;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_load_on_rise: assert property (load_req |=> time_load)
    else $error("load pulse missing");
  a_load_cause: assert property (time_load |-> $past(load_req))
    else $error("load pulse without rising write");
  a_retention_wr: assert property (cfg2_wr |=> retention_mode_sel == $past(reg_wdata[6]))
    else $error("retention bit not taken");
  a_retention_hold: assert property (!cfg2_wr |=> $stable(retention_mode_sel))
    else $error("retention bit moved");
  a_thresh_wr: assert property (cfg2_wr |=> comparator_threshold_sel == $past(reg_wdata[5:4]))
    else $error("threshold code not taken");
  a_timeout_wr: assert property (cfg2_wr |=> bus_timeout_en == $past(reg_wdata[3]))
    else $error("timeout enable not taken");
  a_reset_defaults: assert property ($past(rst) |->
    bus_timeout_en && !retention_mode_sel && comparator_threshold_sel == 2'b00)
    else $error("config defaults wrong");
  a_pin_mux: assert property (!output_function_sel |-> irq_pin_out == square_wave)
    else $error("pin not square wave");
  a_irq_no_enable: assert property (output_function_sel && ien_ff == 8'h00 &&
    ien_old_ff == 8'h00 |-> !irq_pin_out)
    else $error("irq with all enables off");
  c_load: cover property (time_load);
  c_irq: cover property (output_function_sel && irq_pin_out);
  c_status_rd: cover property (reg_rd && reg_addr == 8'h05);
endmodule : rtcr_ctrl_regs_checker

bind rtcr_ctrl_regs rtcr_ctrl_regs_checker u_chk (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .square_wave(square_wave),
  .output_function_sel(output_function_sel), .retention_mode_sel(retention_mode_sel),
  .comparator_threshold_sel(comparator_threshold_sel), .bus_timeout_en(bus_timeout_en),
  .time_load(time_load), .irq_pin_out(irq_pin_out));

//--- testbench/rtcr_host.sv
// Host model issuing single-byte register accesses
`timescale 1ns/1ps
module rtcr_host
(
  input wire logic       ref_clk,
  output logic     [7:0] reg_addr,
  output logic           reg_wr,
  output logic           reg_rd,
  output logic     [7:0] reg_wdata
);
  // Bit 8 set marks a read whose value is not checked
  logic [8:0] exp_q[$];
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Data is inverted once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
endmodule : rtcr_host

//--- testbench/test_rtc_timer_irq_config_regs.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ps
module test_rtc_timer_irq_config_regs;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic        reg_wr, reg_rd, rd_seen = 1'b0;
  logic [55:0] time_live = 56'h0;
  logic        osc = 1'b0, ana = 1'b0, dig = 1'b0, sq = 1'b0, sel = 1'b0, irq;
  logic [8:0]  e;
  logic        al1 = 1'b0, al2 = 1'b0;
  logic [55:0] tprog;
  int          errors = 0, checks = 0, i, n, p;
  int          seed = 32'h0120b06b;
  logic [7:0]  ra [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h20, 8'h05};
  logic [7:0]  rv [6] = '{8'h0c, 8'h00, 8'h07, 8'h00, 8'h00, 8'h40};
  logic [7:0]  mk [5] = '{8'h7e, 8'h60, 8'h37, 8'h77, 8'h00};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) sq <= ~sq;

  rtcr_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  rtcr_ctrl_regs #(.BASE_DIV(4)) uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .time_live(time_live), .alarm1_evt(al1), .alarm2_evt(al2), .osc_stopped(osc),
    .analog_input_pin(ana), .digital_input_pin(dig), .square_wave(sq),
    .output_function_sel(sel), .retention_mode_sel(), .comparator_threshold_sel(),
    .bus_timeout_en(), .time_load(), .time_prog(tprog), .irq_pin_out(irq));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checks++;
    if (got !== ex)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic summarize;
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Read data monitor
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    if (rd_seen)
    begin
      e = host.exp_q.pop_front();
      if (!e[8])
        chk("reg_rdata", e[7:0], reg_rdata);
    end
    rd_seen <= reg_rd;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++)
      host.rd(ra[i], {1'b0, rv[i]});
    for (i = 0; i < 5; i++)
    begin
      // Timer kept stopped so the later counts start clean
      d = 8'($random(seed)) & ((i == 2) ? 8'h07 : 8'hff);
      host.wr(ra[i], d);
      host.rd(ra[i], {1'b0, d & mk[i]});
    end
    d = 8'($random(seed)) & 8'h7f;
    time_live <= {48'h0, d};
    host.wr(8'h06, 8'h35);
    host.wr(8'h01, 8'h04);
    host.rd(8'h06, {1'b0, d});
    host.wr(8'h01, 8'h00);
    host.rd(8'h06, 9'h035);
    chk("time_prog", 8'h35, tprog[7:0]);
    host.wr(8'h01, 8'h02);
    host.wr(8'h01, 8'h02);
    host.rd(8'h05, 9'h100);
    host.wr(8'h02, 8'h60);
    ana <= 1'b1;
    dig <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host.rd(8'h05, 9'h030);
    host.wr(8'h02, 8'h00);
    ana <= 1'b0;
    dig <= 1'b0;
    repeat (3) @(posedge ref_clk);
    host.rd(8'h05, 9'h030);
    ana <= 1'b1;
    dig <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host.rd(8'h05, 9'h000);
    host.wr(8'h04, 8'h40);
    sel <= 1'b1;
    osc <= 1'b1;
    repeat (2) @(posedge ref_clk);
    osc <= 1'b0;
    host.rd(8'h05, 9'h000);
    host.wr(8'h04, 8'h00);
    osc <= 1'b1;
    repeat (2) @(posedge ref_clk);
    osc <= 1'b0;
    host.rd(8'h05, 9'h040);
    // Only alarm one enabled: alarm two must flag without driving the pin
    host.wr(8'h04, 8'h01);
    al2 <= 1'b1;
    @(posedge ref_clk);
    al2 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq_pin_out", 8'h00, {7'h0, irq});
    al1 <= 1'b1;
    @(posedge ref_clk);
    al1 <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq_pin_out", 8'h01, {7'h0, irq});
    host.rd(8'h05, 9'h003);
    @(posedge ref_clk);
    chk("irq_pin_out", 8'h00, {7'h0, irq});
    for (n = 0; n < 4; n++)
    begin
      p = 4 << (2 * n);
      host.wr(8'h03, 8'h00);
      host.wr(8'h10, 8'h04);
      host.rd(8'h05, 9'h100);
      host.wr(8'h03, 8'h10 | 8'(n));
      repeat (p) @(posedge ref_clk);
      host.rd(8'h05, 9'h000);
      repeat (4 * p) @(posedge ref_clk);
      host.rd(8'h05, 9'h004);
    end
    host.wr(8'h03, 8'h00);
    host.wr(8'h10, 8'h20);
    host.rd(8'h05, 9'h100);
    host.wr(8'h03, 8'h10);
    repeat (8) @(posedge ref_clk);
    host.wr(8'h03, 8'h30);
    repeat (300) @(posedge ref_clk);
    host.rd(8'h05, 9'h000);
    host.wr(8'h03, 8'h10);
    repeat (150) @(posedge ref_clk);
    host.rd(8'h05, 9'h004);
    host.wr(8'h03, 8'h00);
    host.wr(8'h10, 8'h02);
    host.wr(8'h04, 8'h04);
    sel <= 1'b1;
    host.rd(8'h05, 9'h100);
    host.wr(8'h03, 8'h14);
    repeat (20) @(posedge ref_clk);
    chk("irq_pin_out", 8'h01, {7'h0, irq});
    host.rd(8'h05, 9'h100);
    repeat (20) @(posedge ref_clk);
    host.rd(8'h05, 9'h004);
    host.wr(8'h03, 8'h00);
    repeat (3) @(posedge ref_clk);
    summarize();
  end
endmodule : test_rtc_timer_irq_config_regs
